// File: hw/psesel_pkg.sv
// Constants, field layout and helpers for the counter 4/5 event selector
package psesel_pkg;

  // ----------------------------------------
  // Bus and register map
  // ----------------------------------------
  localparam int          AXI_ADDR_W = 12;
  localparam int          AXI_DATA_W = 32;
  localparam int          CTR_W      = 32;
  localparam logic [11:0] CTRL_OFF   = 12'h028;
  localparam logic [11:0] CTR4_OFF   = 12'h050;
  localparam logic [11:0] CTR5_OFF   = 12'h054;
  localparam logic [11:0] STAT_OFF   = 12'h058;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int          C4_PRI_LSB   = 0;
  localparam int          C4_DIR_BIT   = 7;
  localparam int          C4_CLASS_LSB = 13;
  localparam int          C5_PRI_LSB   = 16;
  localparam int          C5_DIR_BIT   = 23;
  localparam int          C5_CLASS_LSB = 29;
  localparam logic [31:0] CTRL_RW_MASK = 32'he08f_e08f;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] CTR_RESET    = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

  // Status register bits
  localparam int ST_EN4_BIT  = 0;
  localparam int ST_EN5_BIT  = 1;
  localparam int ST_SAT4_BIT = 2;
  localparam int ST_SAT5_BIT = 3;

  // ----------------------------------------
  // Event class codes
  // ----------------------------------------
  localparam logic [2:0] CLS_UNI_REQ   = 3'h0;
  localparam logic [2:0] CLS_UNI_ALL   = 3'h1;
  localparam logic [2:0] CLS_RETRY_SYM = 3'h2;
  localparam logic [2:0] CLS_OTHER_SYM = 3'h3;
  localparam logic [2:0] CLS_UNI_WORD  = 3'h4;
  localparam logic [2:0] CLS_MC_PKT    = 3'h5;
  localparam logic [2:0] CLS_MC_SYM    = 3'h6;
  localparam logic [2:0] CLS_MC_WORD   = 3'h7;

  // Byte strobes to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // Priority p is selected by bit 3-p of the select nibble
  function automatic logic prio_hit(input logic [3:0] sel, input logic [1:0] prio);
    return sel[2'(2'h3 - prio)];
  endfunction

endpackage

// File: hw/psesel_match.sv
// Event classifier: one increment request per matching event
`timescale 1ns/1ps
module psesel_match (
  input  wire logic [2:0]      ev_class,
  input  wire logic [3:0]      prio_sel,
  input  wire logic            dir_tx,
  input  wire logic [1:0]      ev_pkt_valid,
  input  wire logic [1:0]      ev_pkt_mcast,
  input  wire logic [1:0]      ev_pkt_req,
  input  wire logic [1:0]      ev_pkt_retried,
  input  wire logic [1:0][1:0] ev_pkt_prio,
  input  wire logic [1:0]      ev_word_valid,
  input  wire logic [1:0]      ev_word_mcast,
  input  wire logic [1:0]      ev_word_retried,
  input  wire logic [1:0][1:0] ev_word_prio,
  input  wire logic [1:0]      ev_sym_valid,
  input  wire logic [1:0]      ev_sym_retry,
  input  wire logic [1:0]      ev_sym_mcast,
  output logic                 enabled,
  output logic                 inc
);

  logic       pv;
  logic       pm;
  logic       pq;
  logic       pr;
  logic [1:0] pp;
  logic       wv;
  logic       wm;
  logic       wr;
  logic [1:0] wp;
  logic       sv;
  logic       sr;
  logic       sm;
  logic       hit_p;
  logic       hit_w;
  logic       raw;

  // ----------------------------------------
  // Direction select
  // ----------------------------------------
  assign pv    = ev_pkt_valid[dir_tx];
  assign pm    = ev_pkt_mcast[dir_tx];
  assign pq    = ev_pkt_req[dir_tx];
  assign pr    = ev_pkt_retried[dir_tx];
  assign pp    = ev_pkt_prio[dir_tx];
  assign wv    = ev_word_valid[dir_tx];
  assign wm    = ev_word_mcast[dir_tx];
  assign wr    = ev_word_retried[dir_tx];
  assign wp    = ev_word_prio[dir_tx];
  assign sv    = ev_sym_valid[dir_tx];
  assign sr    = ev_sym_retry[dir_tx];
  assign sm    = ev_sym_mcast[dir_tx];
  assign hit_p = psesel_pkg::prio_hit(prio_sel, pp);
  assign hit_w = psesel_pkg::prio_hit(prio_sel, wp);

  // ----------------------------------------
  // Class decode
  // ----------------------------------------
  always_comb begin
    case (ev_class)
      psesel_pkg::CLS_UNI_REQ:   raw = pv & ~pm & pq & ~pr & hit_p;
      psesel_pkg::CLS_UNI_ALL:   raw = pv & ~pm & ~pr & hit_p;
      psesel_pkg::CLS_RETRY_SYM: raw = sv & sr;
      psesel_pkg::CLS_OTHER_SYM: raw = sv & ~sr;
      psesel_pkg::CLS_UNI_WORD:  raw = wv & ~wm & ~wr & hit_w;
      psesel_pkg::CLS_MC_PKT:    raw = pv & pm & ~pr & hit_p;
      psesel_pkg::CLS_MC_SYM:    raw = sv & sm;
      psesel_pkg::CLS_MC_WORD:   raw = wv & wm & ~wr & hit_w;
      default:                   raw = 1'b0;
    endcase
  end

  // No priority selected means the counter sleeps
  assign enabled = |prio_sel;
  assign inc     = enabled & raw;

endmodule

// File: hw/psesel_counter.sv
// Saturating statistics counter with clear-on-read and test write
`timescale 1ns/1ps
module psesel_counter #(
  parameter int W = psesel_pkg::CTR_W
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic         inc,
  input  wire logic         rd_clr,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  output logic [W-1:0]      count_q,
  output logic              saturated
);

  localparam logic [W-1:0] MAX_VAL = {W{1'b1}};
  localparam logic [W-1:0] ONE_VAL = W'(1);

  assign saturated = (count_q == MAX_VAL);

  // ----------------------------------------
  // Count
  // ----------------------------------------
  // An event coinciding with the read-clear is kept: it starts the next count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= W'(psesel_pkg::CTR_RESET);
    end else if (ce) begin
      if (wr_en) begin
        count_q <= wr_data;
      end else if (rd_clr) begin
        count_q <= inc ? ONE_VAL : '0;
      end else if (inc && !saturated) begin
        count_q <= count_q + ONE_VAL;
      end
    end
  end

endmodule

// File: hw/psesel_top.sv
// Counter 4/5 event selector: control register, counters and AXI4-Lite slave
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module psesel_top #(
  parameter int ADDR_W = psesel_pkg::AXI_ADDR_W,
  parameter int CNT_W  = psesel_pkg::CTR_W
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [1:0]        ev_pkt_valid,
  input  wire logic [1:0]        ev_pkt_mcast,
  input  wire logic [1:0]        ev_pkt_req,
  input  wire logic [1:0]        ev_pkt_retried,
  input  wire logic [1:0][1:0]   ev_pkt_prio,
  input  wire logic [1:0]        ev_word_valid,
  input  wire logic [1:0]        ev_word_mcast,
  input  wire logic [1:0]        ev_word_retried,
  input  wire logic [1:0][1:0]   ev_word_prio,
  input  wire logic [1:0]        ev_sym_valid,
  input  wire logic [1:0]        ev_sym_retry,
  input  wire logic [1:0]        ev_sym_mcast,
  output logic                   ctr4_enabled,
  output logic                   ctr5_enabled
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [31:0]       ctrl_q;
  logic [2:0]        ctr4_event_class;
  logic [2:0]        ctr5_event_class;
  logic [3:0]        ctr4_priority_select;
  logic              ctr5_pri3_sel;
  logic              ctr5_pri2_sel;
  logic              ctr5_pri1_sel;
  logic              ctr5_pri0_sel;
  logic [3:0]        ctr5_priority_select;
  logic              ctr4_direction;
  logic              ctr5_direction;

  logic              aw_full_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic              w_full_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              do_write;
  logic              rd_fire;
  logic [31:0]       wmask;

  logic              inc4;
  logic              inc5;
  logic              en4;
  logic              en5;
  logic [CNT_W-1:0]  ctr4_q;
  logic [CNT_W-1:0]  ctr5_q;
  logic              sat4;
  logic              sat5;
  logic              wr_ctrl;
  logic              wr_ctr4;
  logic              wr_ctr5;
  logic              clr4;
  logic              clr5;
  logic [31:0]       stat_word;

  // Address decode shared by both channels
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [11:0] off);
    return a == ADDR_W'(off);
  endfunction

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    return addr_is(a, psesel_pkg::CTRL_OFF) || addr_is(a, psesel_pkg::CTR4_OFF) ||
           addr_is(a, psesel_pkg::CTR5_OFF) || addr_is(a, psesel_pkg::STAT_OFF);
  endfunction

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  assign ctr4_priority_select = ctrl_q[psesel_pkg::C4_PRI_LSB +: 4];
  assign ctr4_direction       = ctrl_q[psesel_pkg::C4_DIR_BIT];
  assign ctr4_event_class     = ctrl_q[psesel_pkg::C4_CLASS_LSB +: 3];
  assign ctr5_pri3_sel        = ctrl_q[psesel_pkg::C5_PRI_LSB];
  assign ctr5_pri2_sel        = ctrl_q[psesel_pkg::C5_PRI_LSB + 1];
  assign ctr5_pri1_sel        = ctrl_q[psesel_pkg::C5_PRI_LSB + 2];
  assign ctr5_pri0_sel        = ctrl_q[psesel_pkg::C5_PRI_LSB + 3];
  assign ctr5_priority_select = {ctr5_pri0_sel, ctr5_pri1_sel, ctr5_pri2_sel, ctr5_pri3_sel};
  assign ctr5_direction       = ctrl_q[psesel_pkg::C5_DIR_BIT];
  assign ctr5_event_class     = ctrl_q[psesel_pkg::C5_CLASS_LSB +: 3];

  // ----------------------------------------
  // Write channels
  // ----------------------------------------
  // Ready outputs drop with ce so nothing is taken while state is frozen
  assign s_axi_awready = ce & ~aw_full_q;
  assign s_axi_wready  = ce & ~w_full_q;
  assign do_write      = ce & aw_full_q & w_full_q & ~s_axi_bvalid;
  assign wmask         = psesel_pkg::strb_mask(w_strb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      w_data_q <= psesel_pkg::ZERO_WORD;
      w_strb_q <= 4'h0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= psesel_pkg::RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_mapped(aw_addr_q) ? psesel_pkg::RESP_OKAY
                                               : psesel_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign wr_ctrl = do_write & addr_is(aw_addr_q, psesel_pkg::CTRL_OFF);
  assign wr_ctr4 = do_write & addr_is(aw_addr_q, psesel_pkg::CTR4_OFF);
  assign wr_ctr5 = do_write & addr_is(aw_addr_q, psesel_pkg::CTR5_OFF);

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Only the defined fields hold state; reserved bits stay zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= psesel_pkg::CTRL_RESET;
    end else if (ce && wr_ctrl) begin
      ctrl_q <= (ctrl_q & ~(wmask & psesel_pkg::CTRL_RW_MASK)) |
                (w_data_q & wmask & psesel_pkg::CTRL_RW_MASK);
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  assign s_axi_arready = ce & ~s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid & s_axi_arready;
  assign clr4          = rd_fire & addr_is(s_axi_araddr, psesel_pkg::CTR4_OFF);
  assign clr5          = rd_fire & addr_is(s_axi_araddr, psesel_pkg::CTR5_OFF);

  always_comb begin
    stat_word                          = psesel_pkg::ZERO_WORD;
    stat_word[psesel_pkg::ST_EN4_BIT]  = en4;
    stat_word[psesel_pkg::ST_EN5_BIT]  = en5;
    stat_word[psesel_pkg::ST_SAT4_BIT] = sat4;
    stat_word[psesel_pkg::ST_SAT5_BIT] = sat5;
  end

  // Read data captures the count before the clear lands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= psesel_pkg::ZERO_WORD;
      s_axi_rresp  <= psesel_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= psesel_pkg::RESP_OKAY;
        if (addr_is(s_axi_araddr, psesel_pkg::CTRL_OFF)) begin
          s_axi_rdata <= ctrl_q;
        end else if (addr_is(s_axi_araddr, psesel_pkg::CTR4_OFF)) begin
          s_axi_rdata <= 32'(ctr4_q);
        end else if (addr_is(s_axi_araddr, psesel_pkg::CTR5_OFF)) begin
          s_axi_rdata <= 32'(ctr5_q);
        end else if (addr_is(s_axi_araddr, psesel_pkg::STAT_OFF)) begin
          s_axi_rdata <= stat_word;
        end else begin
          s_axi_rdata <= psesel_pkg::ZERO_WORD;
          s_axi_rresp <= psesel_pkg::RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Event matching
  // ----------------------------------------
  psesel_match u_match4 (
    .ev_class        (ctr4_event_class),
    .prio_sel        (ctr4_priority_select),
    .dir_tx          (ctr4_direction),
    .ev_pkt_valid    (ev_pkt_valid),
    .ev_pkt_mcast    (ev_pkt_mcast),
    .ev_pkt_req      (ev_pkt_req),
    .ev_pkt_retried  (ev_pkt_retried),
    .ev_pkt_prio     (ev_pkt_prio),
    .ev_word_valid   (ev_word_valid),
    .ev_word_mcast   (ev_word_mcast),
    .ev_word_retried (ev_word_retried),
    .ev_word_prio    (ev_word_prio),
    .ev_sym_valid    (ev_sym_valid),
    .ev_sym_retry    (ev_sym_retry),
    .ev_sym_mcast    (ev_sym_mcast),
    .enabled         (en4),
    .inc             (inc4)
  );

  psesel_match u_match5 (
    .ev_class        (ctr5_event_class),
    .prio_sel        (ctr5_priority_select),
    .dir_tx          (ctr5_direction),
    .ev_pkt_valid    (ev_pkt_valid),
    .ev_pkt_mcast    (ev_pkt_mcast),
    .ev_pkt_req      (ev_pkt_req),
    .ev_pkt_retried  (ev_pkt_retried),
    .ev_pkt_prio     (ev_pkt_prio),
    .ev_word_valid   (ev_word_valid),
    .ev_word_mcast   (ev_word_mcast),
    .ev_word_retried (ev_word_retried),
    .ev_word_prio    (ev_word_prio),
    .ev_sym_valid    (ev_sym_valid),
    .ev_sym_retry    (ev_sym_retry),
    .ev_sym_mcast    (ev_sym_mcast),
    .enabled         (en5),
    .inc             (inc5)
  );

  assign ctr4_enabled = en4;
  assign ctr5_enabled = en5;

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  // Byte strobes merge into the current count on a test write
  psesel_counter #(
    .W (CNT_W)
  ) u_ctr4 (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .inc       (inc4),
    .rd_clr    (clr4),
    .wr_en     (wr_ctr4),
    .wr_data   (CNT_W'((32'(ctr4_q) & ~wmask) | (w_data_q & wmask))),
    .count_q   (ctr4_q),
    .saturated (sat4)
  );

  psesel_counter #(
    .W (CNT_W)
  ) u_ctr5 (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .inc       (inc5),
    .rd_clr    (clr5),
    .wr_en     (wr_ctr5),
    .wr_data   (CNT_W'((32'(ctr5_q) & ~wmask) | (w_data_q & wmask))),
    .count_q   (ctr5_q),
    .saturated (sat5)
  );

endmodule

// File: bench/psesel_chk_assertions.sv
// Port-level assertions for the counter 4/5 event selector
`timescale 1ns/1ps
module psesel_chk #(
  parameter int ADDR_W = 12
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              ctr4_enabled,
  input wire logic              ctr5_enabled
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic wr_go;
  logic rd_go;
  // Only full-word writes taken in one cycle, so the data is known
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce
    && s_axi_awaddr == psesel_pkg::CTRL_OFF && s_axi_wstrb == 4'hf;
  assign rd_go = s_axi_arvalid && s_axi_arready && ce;

  AST_EN4: assert property (wr_go ##1 ce |-> ##1 ctr4_enabled == |$past(s_axi_wdata[3:0], 2))
    else $error("counter 4 enable does not follow its priority bits");
  AST_EN5: assert property (wr_go ##1 ce |-> ##1 ctr5_enabled == |$past(s_axi_wdata[19:16], 2))
    else $error("counter 5 enable does not follow its priority bits");
  AST_RESV: assert property (rd_go && s_axi_araddr == psesel_pkg::CTRL_OFF |=>
    (s_axi_rdata & ~psesel_pkg::CTRL_RW_MASK) == 32'h0000_0000)
    else $error("reserved control bits read nonzero");
  AST_UNMAP: assert property (rd_go && s_axi_araddr == 12'hff0 |=> s_axi_rvalid
    && s_axi_rresp == psesel_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  AST_BRESP: assert property (wr_go ##1 ce |=> s_axi_bvalid && s_axi_bresp == 2'h0)
    else $error("control write response missing");
  AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before accepted");
  AST_ARRDY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while answer pending");
  AST_RVALID: assert property ($rose(s_axi_rvalid) |-> $past(rd_go))
    else $error("read answer without a request");

  cover property (wr_go);
  cover property (s_axi_rvalid && !s_axi_rready);
  cover property ($rose(ctr5_enabled));
endmodule

// File: bench/psesel_top_tb.sv
// Self-checking bench for the counter 4/5 event selector
`timescale 1ns/1ps
module psesel_top_tb;
  logic            aclk, aresetn, ce;
  logic [11:0]     s_axi_awaddr, s_axi_araddr;
  logic [31:0]     s_axi_wdata, s_axi_rdata;
  logic [3:0]      s_axi_wstrb;
  logic            s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic            s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic            s_axi_rvalid, s_axi_rready, ctr4_enabled, ctr5_enabled;
  logic [1:0]      s_axi_bresp, s_axi_rresp;
  logic [1:0]      ev_pkt_valid, ev_pkt_mcast, ev_pkt_req, ev_pkt_retried;
  logic [1:0]      ev_word_valid, ev_word_mcast, ev_word_retried;
  logic [1:0]      ev_sym_valid, ev_sym_retry, ev_sym_mcast;
  logic [1:0][1:0] ev_pkt_prio, ev_word_prio;
  int              bad_count, comparisons;

  psesel_top dut_u (.*);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic hang();
    chk(32'h0, 32'h1);
    complete_run();
  endtask

  function automatic logic [31:0] cw(input logic [2:0] c4, input logic [3:0] p4, input logic d4,
      input logic [2:0] c5, input logic [3:0] p5, input logic d5);
    return {c5, 5'h00, d5, 3'h0, p5, c4, 5'h00, d4, 3'h0, p4};
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; !(aw_ok && w_ok); n++) begin
      @(posedge aclk);
      if (n > 50) hang();
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    for (int n = 0; !s_axi_bvalid; n++) begin
      @(posedge aclk);
      if (n > 50) hang();
    end
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask

  // Ready raised late on purpose so the answer has to stand
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic ar_ok;
    ar_ok = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int n = 0; !ar_ok; n++) begin
      @(posedge aclk);
      if (n > 50) hang();
      if (s_axi_arvalid && s_axi_arready) begin
        ar_ok = 1;
        s_axi_arvalid <= 1'b0;
      end
    end
    for (int n = 0; !s_axi_rvalid; n++) begin
      @(posedge aclk);
      if (n > 50) hang();
    end
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk(32'(s_axi_rresp), 32'(er));
  endtask

  // Kinds: 0 req, 1 resp, 2 mc pkt, 3 retried req, 4 retry sym, 5 sym, 6 mc sym,
  // 7 word, 8 mc word, 9 retried word
  task automatic fire(input int k, input logic d, input logic [1:0] p);
    logic [1:0] m;
    m = d ? 2'h2 : 2'h1;
    @(posedge aclk);
    ev_pkt_valid <= (k < 4) ? m : 2'h0;
    ev_pkt_mcast <= (k == 2) ? m : 2'h0;
    ev_pkt_req <= (k == 0 || k == 3) ? m : 2'h0;
    ev_pkt_retried <= (k == 3) ? m : 2'h0;
    ev_pkt_prio <= {p, p};
    ev_word_valid <= (k > 6) ? m : 2'h0;
    ev_word_mcast <= (k == 8) ? m : 2'h0;
    ev_word_retried <= (k == 9) ? m : 2'h0;
    ev_word_prio <= {p, p};
    ev_sym_valid <= (k > 3 && k < 7) ? m : 2'h0;
    ev_sym_retry <= (k == 4) ? m : 2'h0;
    ev_sym_mcast <= (k == 6) ? m : 2'h0;
    @(posedge aclk);
    ev_pkt_valid <= 2'h0;
    ev_word_valid <= 2'h0;
    ev_sym_valid <= 2'h0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Kind k fired k+1 times, so every class but CLS_UNI_ALL and CLS_MC_PKT (both 3) gives a distinct total
  task automatic class_sweep();
    int exp [8] = '{1, 3, 5, 13, 8, 3, 7, 9};
    for (int c = 0; c < 8; c++) begin
      wr(psesel_pkg::CTRL_OFF, cw(3'(c), 4'hf, 1'b0, 3'(7 - c), 4'hf, 1'b0), 2'h0);
      for (int k = 0; k < 10; k++) repeat (k + 1) fire(k, 1'b0, 2'h2);
      rd(psesel_pkg::CTR4_OFF, 32'(exp[c]), 2'h0);
      rd(psesel_pkg::CTR5_OFF, 32'(exp[7 - c]), 2'h0);
    end
    rd(psesel_pkg::CTR4_OFF, 32'h0, 2'h0);
  endtask

  task automatic prio_sweep();
    for (int p = 0; p < 4; p++) begin
      wr(psesel_pkg::CTRL_OFF, cw(3'h1, 4'hf, 1'b0, 3'h1, 4'h8 >> p, 1'b1), 2'h0);
      chk(32'(ctr5_enabled), 32'h1);
      for (int q = 0; q < 4; q++) fire(1, 1'b1, 2'(q));
      fire(1, 1'b0, 2'(p));
      rd(psesel_pkg::CTR5_OFF, 32'h1, 2'h0);
      rd(psesel_pkg::CTR4_OFF, 32'h1, 2'h0);
    end
    wr(psesel_pkg::CTRL_OFF, cw(3'h1, 4'h0, 1'b0, 3'h1, 4'h0, 1'b1), 2'h0);
    chk(32'(ctr4_enabled), 32'h0);
    chk(32'(ctr5_enabled), 32'h0);
    fire(1, 1'b1, 2'h0);
    fire(1, 1'b0, 2'h0);
    rd(psesel_pkg::CTR5_OFF, 32'h0, 2'h0);
    rd(psesel_pkg::CTR4_OFF, 32'h0, 2'h0);
  endtask

  // Saturation, status view, then a frozen clock enable drops events
  task automatic saturate_freeze();
    wr(psesel_pkg::CTRL_OFF, cw(3'h1, 4'hf, 1'b0, 3'h0, 4'h0, 1'b0), 2'h0);
    wr(psesel_pkg::CTR4_OFF, 32'hffff_fffe, 2'h0);
    repeat (3) fire(0, 1'b0, 2'h0);
    rd(psesel_pkg::STAT_OFF, 32'h0000_0005, 2'h0);
    rd(psesel_pkg::CTR4_OFF, 32'hffff_ffff, 2'h0);
    rd(psesel_pkg::CTR4_OFF, 32'h0, 2'h0);
    @(posedge aclk);
    ce <= 1'b0;
    repeat (2) fire(0, 1'b0, 2'h0);
    ce <= 1'b1;
    rd(psesel_pkg::CTR4_OFF, 32'h0, 2'h0);
  endtask

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  initial begin
    {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, ev_pkt_valid, ev_pkt_mcast, ev_pkt_req} = '0;
    {ev_pkt_retried, ev_word_valid, ev_word_mcast, ev_word_retried, ev_sym_valid} = '0;
    {ev_sym_retry, ev_sym_mcast, ev_pkt_prio, ev_word_prio, bad_count, comparisons} = '0;
    ce = 1'b1;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(psesel_pkg::CTRL_OFF, 32'h0, 2'h0);
    rd(psesel_pkg::CTR4_OFF, 32'h0, 2'h0);
    wr(psesel_pkg::CTRL_OFF, 32'hffff_ffff, 2'h0);
    rd(psesel_pkg::CTRL_OFF, psesel_pkg::CTRL_RW_MASK, 2'h0);
    rd(12'hff0, 32'h0, psesel_pkg::RESP_SLVERR);
    wr(12'hff0, 32'h1, psesel_pkg::RESP_SLVERR);
    class_sweep();
    prio_sweep();
    saturate_freeze();
    complete_run();
  end
endmodule

bind psesel_top psesel_chk #(.ADDR_W(ADDR_W)) chk_u (.*);
